//--- rtl/scmc_clkdiv.sv
// Recovered clock output divider for one channel
`timescale 1ns/1ps
module scmc_clkdiv (
    // Clock and reset
    input  wire logic       clk_in,
    input  wire logic       srst_in,
    // Source and setting
    input  wire logic       tick_in,
    input  wire logic       on_in,
    input  wire logic [4:0] divisor_in,
    // Divided level
    output logic            level_out
);
    typedef struct packed {
        logic [4:0] cnt;
        logic       lvl;
    } scmc_div_t;

    scmc_div_t q;
    scmc_div_t next_q;

    // Ticks mark every source edge, so N ticks per half period gives divide by N
    always_comb begin
        next_q = q;
        if (!on_in) begin
            next_q.cnt = 5'h00;
            next_q.lvl = 1'b0;
        end else if (tick_in) begin
            if (q.cnt >= divisor_in - 5'h01) begin
                next_q.cnt = 5'h00;
                next_q.lvl = ~q.lvl;
            end else begin
                next_q.cnt = q.cnt + 5'h01;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign level_out = q.lvl;
endmodule

//--- rtl/scmc_pkg.sv
// Shared constants for the channel clock and mode configuration block
package scmc_pkg;
    // ==========================================================
    // Management frame
    localparam logic [4:0]  DEVAD        = 5'h1E;
    localparam logic [5:0]  PRE_LEN      = 6'h20;
    localparam logic [5:0]  HDR_LAST     = 6'h0C;
    localparam logic [5:0]  DATA_LAST    = 6'h0F;
    localparam logic [1:0]  OP_ADDR      = 2'h0;
    localparam logic [1:0]  OP_WRITE     = 2'h1;
    localparam logic [1:0]  OP_READINC   = 2'h2;
    localparam logic [1:0]  OP_READ      = 2'h3;
    // ==========================================================
    // Register addresses and reset values
    localparam logic [15:0] CTL_ADDR     = 16'h0001;
    localparam logic [15:0] PLL_ADDR     = 16'h0002;
    localparam logic [15:0] CTL_RST      = 16'h0B88;
    localparam logic [15:0] PLL_RST      = 16'h811D;
    // ==========================================================
    // Channel control fields
    localparam int CTL_SLEEP     = 15;
    localparam int CTL_KR        = 11;
    localparam int CTL_DEVOVR    = 10;
    localparam int CTL_DIV_HI    = 7;
    localparam int CTL_DIV_LO    = 4;
    localparam int CTL_CLK_ON    = 3;
    localparam int CTL_CLK_SRC   = 2;
    localparam int CTL_FAST_REF  = 1;
    localparam int CTL_SLOW_REF  = 0;
    // ==========================================================
    // PLL control fields and channel count
    localparam int PLL_BW_HI     = 9;
    localparam int PLL_BW_LO     = 8;
    localparam int PLL_VLOW      = 6;
    localparam int PLL_ON        = 4;
    localparam int PLL_MUL_HI    = 3;
    localparam int PLL_MUL_LO    = 0;
    localparam int NCH           = 4;
endpackage

//--- rtl/scmc_top.sv
// Per-channel clock, reference and PLL configuration with a management slave
// Functional notes
// - KR coding bit honoured only with mode pin low, autoneg off, override clear
// - Device mode override needs mode pin low
// - Divider codes give divide by 1,2,4,8,16,5,10,20,25
// - Clock enable low holds output pins fixed
// - Source bit picks byte clock or VCO/2
// - Fast reference bit used only pin low
// - Slow reference same or alternate of fast
// - Loop width resets narrow, code 00 reserved
// - PLL off on sleep pin or bit
// - Multiplier from software only when overridden or reference pick set
// - PLL register at 0x0002, device 0x1E, 0x811D
// - Reserved PLL bits reset and stay writable
// - Sleep bit powers down channel, management alive
// - Multiplier codes map to documented factors
`timescale 1ns/1ps
module scmc_top (
    // Clock and reset
    input  wire logic        clk_in,
    input  wire logic        srst_in,
    // Management pins
    input  wire logic        mdc_in,
    input  wire logic        mdio_in,
    output logic             mdio_out,
    output logic             mdio_oe_out,
    input  wire logic [2:0]  port_base_in,
    // Device pins
    input  wire logic        mode_pin_in,
    input  wire logic        ref_choice_pin_in,
    input  wire logic [3:0]  channel_sleep_pin_n_in,
    // Other device state
    input  wire logic [3:0]  autoneg_on_in,
    input  wire logic [3:0]  ref_frequency_pick_one_in,
    input  wire logic [3:0]  mult_override_in,
    input  wire logic [15:0] auto_multiplier_in,
    input  wire logic [3:0]  byte_clk_edge_in,
    input  wire logic [3:0]  vco_half_edge_in,
    // Channel controls
    output logic [3:0]       kr_mode_out,
    output logic [3:0]       device_mode_sw_out,
    output logic [3:0]       channel_sleep_out,
    output logic [3:0]       fast_ref_one_out,
    output logic [3:0]       slow_ref_one_out,
    output logic [3:0]       pll_on_out,
    output logic [3:0]       vco_low_band_out,
    output logic [7:0]       pll_loop_width_out,
    output logic [15:0]      pll_multiplier_out,
    output logic [31:0]      pll_factor_q_out,
    // Recovered clock pins
    output logic [3:0]       recovered_clock_pins_p_out,
    output logic [3:0]       recovered_clock_pins_n_out
);
    typedef enum logic [1:0] {S_PRE, S_HDR, S_TA, S_DATA} scmc_st_t;

    typedef struct packed {
        logic [2:0]       mdc_s;
        logic [2:0]       mdio_s;
        logic [2:0]       mode_s;
        logic [2:0]       rsel_s;
        logic [3:0][2:0]  sleep_s;
        logic             mdc_f;
        logic             mdio_f;
        logic             mode_f;
        logic             rsel_f;
        logic [3:0]       sleep_f;
        scmc_st_t         st;
        logic [5:0]       cnt;
        logic [12:0]      hdr;
        logic             hit;
        logic [15:0]      sh;
        logic             mo;
        logic             moe;
        logic [3:0][15:0] addr;
        logic [3:0][15:0] ctl;
        logic [3:0][15:0] pll;
        logic [3:0]       kr;
        logic [3:0]       devsw;
        logic [3:0]       slp;
        logic [3:0]       fref;
        logic [3:0]       sref;
        logic [3:0]       pon;
        logic [3:0]       vlow;
        logic [3:0][1:0]  bw;
        logic [3:0][3:0]  mul;
        logic [3:0][7:0]  fac;
    } scmc_state_t;

    scmc_state_t q;
    scmc_state_t next_q;
    logic [3:0]  clk_lvl;

    // ==========================================================
    // Decoders
    // Multiplier factor in quarter steps, zero when reserved
    function automatic logic [7:0] mult_quarters(input logic [3:0] code);
        case (code)
            4'h2:    mult_quarters = 8'h10;
            4'h3:    mult_quarters = 8'h14;
            4'h4:    mult_quarters = 8'h18;
            4'h5:    mult_quarters = 8'h20;
            4'h6:    mult_quarters = 8'h21;
            4'h7:    mult_quarters = 8'h28;
            4'h8:    mult_quarters = 8'h30;
            4'h9:    mult_quarters = 8'h32;
            4'hA:    mult_quarters = 8'h3C;
            4'hB:    mult_quarters = 8'h40;
            4'hC:    mult_quarters = 8'h42;
            4'hD:    mult_quarters = 8'h50;
            4'hE:    mult_quarters = 8'h64;
            default: mult_quarters = 8'h00;
        endcase
    endfunction

    // Output divisor, zero when the code is reserved
    function automatic logic [4:0] out_divisor(input logic [3:0] code);
        case (code)
            4'h0:    out_divisor = 5'h01;
            4'h4:    out_divisor = 5'h02;
            4'h8:    out_divisor = 5'h04;
            4'h9:    out_divisor = 5'h08;
            4'hA:    out_divisor = 5'h10;
            4'hC:    out_divisor = 5'h05;
            4'hD:    out_divisor = 5'h0A;
            4'hE:    out_divisor = 5'h14;
            4'hF:    out_divisor = 5'h19;
            default: out_divisor = 5'h00;
        endcase
    endfunction

    function automatic logic [15:0] reg_read(input scmc_state_t s, input logic [1:0] ch);
        if (s.addr[ch] == scmc_pkg::CTL_ADDR) begin
            reg_read = s.ctl[ch];
        end else if (s.addr[ch] == scmc_pkg::PLL_ADDR) begin
            reg_read = s.pll[ch];
        end else begin
            reg_read = 16'h0000;
        end
    endfunction

    // ==========================================================
    // Next state
    always_comb begin
        logic       rise;
        logic       rd;
        logic [1:0] ch;
        logic [15:0] nsh;
        rise   = 1'b0;
        rd     = 1'b0;
        ch     = 2'h0;
        nsh    = 16'h0000;
        next_q = q;
        next_q.mdc_s  = {q.mdc_s[1:0], mdc_in};
        next_q.mdio_s = {q.mdio_s[1:0], mdio_in};
        next_q.mode_s = {q.mode_s[1:0], mode_pin_in};
        next_q.rsel_s = {q.rsel_s[1:0], ref_choice_pin_in};
        if (q.mdc_s[1] == q.mdc_s[2]) next_q.mdc_f = q.mdc_s[2];
        if (q.mdio_s[1] == q.mdio_s[2]) next_q.mdio_f = q.mdio_s[2];
        if (q.mode_s[1] == q.mode_s[2]) next_q.mode_f = q.mode_s[2];
        if (q.rsel_s[1] == q.rsel_s[2]) next_q.rsel_f = q.rsel_s[2];
        for (int i = 0; i < scmc_pkg::NCH; i++) begin
            next_q.sleep_s[i] = {q.sleep_s[i][1:0], channel_sleep_pin_n_in[i]};
            if (q.sleep_s[i][1] == q.sleep_s[i][2]) next_q.sleep_f[i] = q.sleep_s[i][2];
        end
        rise = (q.mdc_s[1] == q.mdc_s[2]) & q.mdc_s[2] & ~q.mdc_f;
        rd   = q.hit & q.hdr[11];
        ch   = q.hdr[6:5];
        // Frame walker, one step per management clock rise
        if (rise) begin
            case (q.st)
                S_PRE: begin
                    if (q.mdio_f) begin
                        next_q.cnt = (q.cnt < scmc_pkg::PRE_LEN) ? q.cnt + 6'h01 : q.cnt;
                    end else if (q.cnt >= scmc_pkg::PRE_LEN) begin
                        next_q.st  = S_HDR;
                        next_q.cnt = 6'h00;
                        next_q.hdr = 13'h0000;
                    end else begin
                        next_q.cnt = 6'h00;
                    end
                end
                S_HDR: begin
                    next_q.hdr = {q.hdr[11:0], q.mdio_f};
                    next_q.cnt = q.cnt + 6'h01;
                    if (q.cnt == scmc_pkg::HDR_LAST) begin
                        next_q.hit = ~next_q.hdr[12] & (next_q.hdr[9:7] == port_base_in)
                                   & (next_q.hdr[4:0] == scmc_pkg::DEVAD);
                        next_q.st  = S_TA;
                        next_q.cnt = 6'h00;
                    end
                end
                S_TA: begin
                    next_q.cnt = q.cnt + 6'h01;
                    if (q.cnt == 6'h00) begin
                        next_q.moe = rd;
                        next_q.mo  = 1'b0;
                    end else begin
                        next_q.st  = S_DATA;
                        next_q.cnt = 6'h00;
                        next_q.sh  = reg_read(q, ch);
                        next_q.mo  = rd & next_q.sh[15];
                    end
                end
                S_DATA: begin
                    nsh = rd ? {q.sh[14:0], 1'b0} : {q.sh[14:0], q.mdio_f};
                    next_q.sh  = nsh;
                    next_q.mo  = rd & nsh[15];
                    next_q.cnt = q.cnt + 6'h01;
                    if (q.cnt == scmc_pkg::DATA_LAST) begin
                        next_q.st  = S_PRE;
                        next_q.cnt = 6'h00;
                        next_q.moe = 1'b0;
                        next_q.mo  = 1'b0;
                        // writes reach only the addressed channel
                        if (q.hit) begin
                            case (q.hdr[11:10])
                                scmc_pkg::OP_ADDR: next_q.addr[ch] = nsh;
                                scmc_pkg::OP_WRITE: begin
                                    if (q.addr[ch] == scmc_pkg::CTL_ADDR) next_q.ctl[ch] = nsh;
                                    if (q.addr[ch] == scmc_pkg::PLL_ADDR) next_q.pll[ch] = nsh;
                                end
                                scmc_pkg::OP_READINC: next_q.addr[ch] = q.addr[ch] + 16'h0001;
                                default: next_q.addr[ch] = q.addr[ch];
                            endcase
                        end
                    end
                end
                default: next_q.st = S_PRE;
            endcase
        end
        // Per-channel controls
        for (int i = 0; i < scmc_pkg::NCH; i++) begin
            // KR coding gated by pin, autoneg and override
            next_q.kr[i] = ~q.mode_f & ~autoneg_on_in[i] & ~q.ctl[i][scmc_pkg::CTL_DEVOVR]
                         & q.ctl[i][scmc_pkg::CTL_KR];
            // override effective with mode pin low
            next_q.devsw[i] = ~q.mode_f & q.ctl[i][scmc_pkg::CTL_DEVOVR];
            // channel sleep from bit or pin
            next_q.slp[i] = q.ctl[i][scmc_pkg::CTL_SLEEP] | ~q.sleep_f[i];
            next_q.fref[i] = q.rsel_f | q.ctl[i][scmc_pkg::CTL_FAST_REF];
            next_q.sref[i] = next_q.fref[i] ^ q.ctl[i][scmc_pkg::CTL_SLOW_REF];
            next_q.pon[i] = q.pll[i][scmc_pkg::PLL_ON] & ~next_q.slp[i];
            next_q.vlow[i] = q.pll[i][scmc_pkg::PLL_VLOW];
            next_q.bw[i] = q.pll[i][scmc_pkg::PLL_BW_HI:scmc_pkg::PLL_BW_LO];
            next_q.mul[i] = (ref_frequency_pick_one_in[i] | mult_override_in[i])
                          ? q.pll[i][scmc_pkg::PLL_MUL_HI:scmc_pkg::PLL_MUL_LO]
                          : auto_multiplier_in[4*i +: 4];
            next_q.fac[i] = mult_quarters(next_q.mul[i]);
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            q      <= '0;
            q.st   <= S_PRE;
            q.ctl  <= {scmc_pkg::NCH{scmc_pkg::CTL_RST}};
            q.pll  <= {scmc_pkg::NCH{scmc_pkg::PLL_RST}};
        end else begin
            q <= next_q;
        end
    end

    // ==========================================================
    // Recovered clock dividers
    genvar g;
    generate
        for (g = 0; g < scmc_pkg::NCH; g++) begin : g_ch
            logic [4:0] div;
            assign div = out_divisor(q.ctl[g][scmc_pkg::CTL_DIV_HI:scmc_pkg::CTL_DIV_LO]);
            scmc_clkdiv u_div (
                .clk_in     (clk_in),
                .srst_in    (srst_in),
                .tick_in    (q.ctl[g][scmc_pkg::CTL_CLK_SRC] ? vco_half_edge_in[g]
                                                             : byte_clk_edge_in[g]),
                .on_in      (q.ctl[g][scmc_pkg::CTL_CLK_ON] & (div != 5'h00)),
                .divisor_in (div),
                .level_out  (clk_lvl[g])
            );
            assign recovered_clock_pins_p_out[g] = clk_lvl[g];
            assign recovered_clock_pins_n_out[g] = ~clk_lvl[g];
            assign pll_loop_width_out[2*g +: 2]  = q.bw[g];
            assign pll_multiplier_out[4*g +: 4]  = q.mul[g];
            assign pll_factor_q_out[8*g +: 8]    = q.fac[g];
        end
    endgenerate

    assign mdio_out           = q.mo;
    assign mdio_oe_out        = q.moe;
    assign kr_mode_out        = q.kr;
    assign device_mode_sw_out = q.devsw;
    assign channel_sleep_out  = q.slp;
    assign fast_ref_one_out   = q.fref;
    assign slow_ref_one_out   = q.sref;
    assign pll_on_out         = q.pon;
    assign vco_low_band_out   = q.vlow;

    // ==========================================================
    // Checks
    chk_pll_sleep_off: assert property (@(posedge clk_in) disable iff (srst_in)
        q.ctl[0][scmc_pkg::CTL_SLEEP] |=> !pll_on_out[0]) else $error("PLL on while asleep");
    chk_kr_pin_gate: assert property (@(posedge clk_in) disable iff (srst_in)
        q.mode_f |=> !kr_mode_out[0]) else $error("KR coding honoured with mode pin high");
    chk_devovr_gate: assert property (@(posedge clk_in) disable iff (srst_in)
        q.mode_f |=> !device_mode_sw_out[0]) else $error("Mode override with pin high");
    chk_fast_ref_pin: assert property (@(posedge clk_in) disable iff (srst_in)
        !q.rsel_f |=> fast_ref_one_out[0] == $past(q.ctl[0][scmc_pkg::CTL_FAST_REF]))
        else $error("Fast reference ignores register bit");
    chk_slow_ref_alt: assert property (@(posedge clk_in) disable iff (srst_in)
        ##1 (fast_ref_one_out[0] ^ slow_ref_one_out[0])
            == $past(q.ctl[0][scmc_pkg::CTL_SLOW_REF]))
        else $error("Slow reference relation broken");
    chk_mult_auto: assert property (@(posedge clk_in) disable iff (srst_in)
        !(ref_frequency_pick_one_in[0] | mult_override_in[0])
        |=> pll_multiplier_out[3:0] == $past(auto_multiplier_in[3:0]))
        else $error("Software multiplier used without override");
    chk_pll_reset: assert property (@(posedge clk_in)
        srst_in |=> q.pll[0] == scmc_pkg::PLL_RST && q.ctl[3] == scmc_pkg::CTL_RST)
        else $error("Wrong register reset value");
    chk_clk_held: assert property (@(posedge clk_in) disable iff (srst_in)
        (!q.ctl[0][scmc_pkg::CTL_CLK_ON])[*2] |-> !recovered_clock_pins_p_out[0])
        else $error("Recovered clock toggles while disabled");
    chk_ta_low: assert property (@(posedge clk_in) disable iff (srst_in)
        $rose(mdio_oe_out) |-> !mdio_out && q.st == S_TA) else $error("Turnaround not low");
    chk_factor_20: assert property (@(posedge clk_in) disable iff (srst_in)
        pll_multiplier_out[3:0] == 4'hD |-> pll_factor_q_out[7:0] == 8'h50)
        else $error("Multiplier factor decode wrong");
    cov_write: cover property (@(posedge clk_in) q.st == S_DATA && q.hit && !q.hdr[11]
        && q.cnt == scmc_pkg::DATA_LAST);
    cov_read: cover property (@(posedge clk_in) $rose(mdio_oe_out));
    cov_clk_toggle: cover property (@(posedge clk_in) $rose(recovered_clock_pins_p_out[1]));
    cov_sleep: cover property (@(posedge clk_in) $fell(pll_on_out[2]));
endmodule

//--- tb/tb.sv
// Self-checking testbench for the channel clock and mode configuration block
`timescale 1ns/1ps
module tb;
    // ==========================================================
    // Stimulus, outputs and counters
    localparam int HALF = 5;
    localparam logic [15:0] CTL = scmc_pkg::CTL_ADDR;
    localparam logic [15:0] PLL = scmc_pkg::PLL_ADDR;
    localparam logic [7:0] FAC [16] = '{8'h00, 8'h00, 8'h10, 8'h14, 8'h18, 8'h20, 8'h21,
        8'h28, 8'h30, 8'h32, 8'h3C, 8'h40, 8'h42, 8'h50, 8'h64, 8'h00};
    localparam logic [3:0] DCODE [9] = '{4'h0, 4'h4, 4'h8, 4'h9, 4'hA, 4'hC, 4'hD, 4'hE, 4'hF};
    localparam int DIVN [9] = '{1, 2, 4, 8, 16, 5, 10, 20, 25};
    logic        clk_in = 1'b0;
    logic        srst_in = 1'b1;
    logic        mdc_in = 1'b0;
    logic        mdio_in = 1'b1;
    logic        mode_pin_in = 1'b0;
    logic        ref_choice_pin_in = 1'b0;
    logic [3:0]  channel_sleep_pin_n_in = 4'hF;
    logic [3:0]  autoneg_on_in = 4'h0;
    logic [3:0]  ref_frequency_pick_one_in = 4'h0;
    logic [3:0]  mult_override_in = 4'h0;
    logic [15:0] auto_multiplier_in = 16'h3333;
    logic [3:0]  byte_clk_edge_in = 4'h0;
    logic [3:0]  vco_half_edge_in = 4'h0;
    logic        mdio_out, mdio_oe_out, oe_seen;
    logic [3:0]  kr_mode_out, device_mode_sw_out, channel_sleep_out, fast_ref_one_out;
    logic [3:0]  slow_ref_one_out, pll_on_out, vco_low_band_out;
    logic [3:0]  recovered_clock_pins_p_out, recovered_clock_pins_n_out;
    logic [7:0]  pll_loop_width_out;
    logic [15:0] pll_multiplier_out, rd;
    logic [31:0] pll_factor_q_out;
    int          t;
    int          n_mismatch = 0;
    int          cmp_count = 0;

    always #2.5 clk_in = ~clk_in;

    scmc_top scmc_top_inst (
        .clk_in, .srst_in, .mdc_in, .mdio_in, .mdio_out, .mdio_oe_out,
        .port_base_in(3'h5), .mode_pin_in, .ref_choice_pin_in, .channel_sleep_pin_n_in,
        .autoneg_on_in, .ref_frequency_pick_one_in, .mult_override_in, .auto_multiplier_in,
        .byte_clk_edge_in, .vco_half_edge_in, .kr_mode_out, .device_mode_sw_out,
        .channel_sleep_out, .fast_ref_one_out, .slow_ref_one_out, .pll_on_out,
        .vco_low_band_out, .pll_loop_width_out, .pll_multiplier_out, .pll_factor_q_out,
        .recovered_clock_pins_p_out, .recovered_clock_pins_n_out
    );

    // ==========================================================
    // Shared tasks
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Management frame; the line floats high from turnaround on reads
    task automatic frame(input logic [1:0] op, input logic [1:0] ch, input logic [4:0] dev,
                         input logic [15:0] dat);
        logic [63:0] bits;
        bits = {32'hFFFFFFFF, 2'b00, op, 3'h5, ch, dev, 2'b10, dat};
        oe_seen = 1'b0;
        for (int i = 0; i < 64; i++) begin
            if (i >= 48) rd[63 - i] = mdio_out;
            oe_seen = oe_seen | mdio_oe_out;
            mdio_in = (op[1] && i >= 46) ? 1'b1 : bits[63 - i];
            cyc(HALF);
            mdc_in = 1'b1;
            cyc(HALF);
            mdc_in = 1'b0;
        end
    endtask

    task automatic reg_wr(input logic [1:0] ch, input logic [15:0] a, input logic [15:0] d);
        frame(scmc_pkg::OP_ADDR, ch, scmc_pkg::DEVAD, a);
        frame(scmc_pkg::OP_WRITE, ch, scmc_pkg::DEVAD, d);
    endtask

    task automatic reg_rd(input logic [1:0] ch, input logic [15:0] a);
        frame(scmc_pkg::OP_ADDR, ch, scmc_pkg::DEVAD, a);
        frame(scmc_pkg::OP_READ, ch, scmc_pkg::DEVAD, 16'h0000);
    endtask

    // Counts output toggles over 400 source pulses on channel zero
    task automatic pulses(input logic vco, output int n);
        logic last;
        n = 0;
        last = recovered_clock_pins_p_out[0];
        for (int k = 0; k < 800; k++) begin
            byte_clk_edge_in = (!vco && k[0] == 1'b0) ? 4'h1 : 4'h0;
            vco_half_edge_in = (vco && k[0] == 1'b0) ? 4'h1 : 4'h0;
            cyc(1);
            if (recovered_clock_pins_p_out[0] !== last) n++;
            last = recovered_clock_pins_p_out[0];
        end
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_reset();
        reg_rd(2'd3, PLL);
        chk("pll reg", rd, scmc_pkg::PLL_RST);
        chk("read drive", oe_seen, 1'b1);
        reg_rd(2'd0, CTL);
        chk("ctl reg", rd, scmc_pkg::CTL_RST);
        chk("pll on", pll_on_out, 4'hF);
        chk("loop width", pll_loop_width_out, 8'h55);
        chk("kr mode", kr_mode_out, 4'hF);
        chk("mode sw", device_mode_sw_out, 4'h0);
        chk("refs", {fast_ref_one_out, slow_ref_one_out}, 8'h00);
        chk("sleep", channel_sleep_out, 4'h0);
        chk("mult auto", pll_multiplier_out, 16'h3333);
        chk("factor", pll_factor_q_out, 32'h14141414);
    endtask

    task automatic t_pll();
        reg_wr(2'd2, PLL, 16'h835E);
        reg_rd(2'd2, PLL);
        chk("pll readback", rd, 16'h835E);
        chk("width ch2", pll_loop_width_out, 8'h75);
        chk("band ch2", vco_low_band_out, 4'h4);
        chk("mult ignored", pll_multiplier_out, 16'h3333);
        ref_frequency_pick_one_in = 4'h4;
        mult_override_in = 4'h2;
        cyc(2);
        chk("mult used", pll_multiplier_out, 16'h3ED3);
        chk("factor used", pll_factor_q_out, 32'h14645014);
        for (int c = 0; c < 16; c++) begin
            reg_wr(2'd2, PLL, 16'h8350 | 16'(c));
            chk("factor code", pll_factor_q_out[23:16], FAC[c]);
        end
        reg_wr(2'd2, PLL, scmc_pkg::PLL_RST);
        ref_frequency_pick_one_in = 4'h0;
        mult_override_in = 4'h0;
        reg_rd(2'd0, 16'h0005);
        chk("unmapped", rd, 16'h0000);
        frame(scmc_pkg::OP_READ, 2'd0, 5'h1D, 16'h0000);
        chk("foreign device", oe_seen, 1'b0);
    endtask

    task automatic t_power();
        reg_wr(2'd0, CTL, 16'h8B88);
        channel_sleep_pin_n_in = 4'h7;
        cyc(8);
        chk("sleep", channel_sleep_out, 4'h9);
        chk("pll off", pll_on_out, 4'h6);
        reg_rd(2'd0, CTL);
        chk("mgmt alive", rd, 16'h8B88);
        channel_sleep_pin_n_in = 4'hF;
        reg_wr(2'd0, CTL, scmc_pkg::CTL_RST);
        chk("awake", pll_on_out, 4'hF);
    endtask

    task automatic t_mode();
        autoneg_on_in = 4'h2;
        reg_wr(2'd2, CTL, 16'h0F88);
        chk("kr", kr_mode_out, 4'h9);
        chk("mode sw", device_mode_sw_out, 4'h4);
        mode_pin_in = 1'b1;
        cyc(8);
        chk("kr pin", kr_mode_out, 4'h0);
        chk("mode sw pin", device_mode_sw_out, 4'h0);
        mode_pin_in = 1'b0;
        autoneg_on_in = 4'h0;
        reg_wr(2'd2, CTL, 16'h0388);
        chk("kr bit", kr_mode_out, 4'hB);
        reg_wr(2'd2, CTL, scmc_pkg::CTL_RST);
    endtask

    task automatic t_ref();
        reg_wr(2'd1, CTL, 16'h0B8B);
        chk("fast", fast_ref_one_out, 4'h2);
        chk("slow", slow_ref_one_out, 4'h0);
        reg_wr(2'd1, CTL, 16'h0B89);
        chk("fast", fast_ref_one_out, 4'h0);
        chk("slow", slow_ref_one_out, 4'h2);
        ref_choice_pin_in = 1'b1;
        cyc(8);
        chk("fast pin", fast_ref_one_out, 4'hF);
        chk("slow pin", slow_ref_one_out, 4'hD);
        ref_choice_pin_in = 1'b0;
        reg_wr(2'd1, CTL, scmc_pkg::CTL_RST);
    endtask

    task automatic t_div();
        for (int j = 0; j < 9; j++) begin
            reg_wr(2'd0, CTL, 16'h0B08 | {8'h00, DCODE[j], 4'h0});
            pulses(1'b0, t);
            chk("toggles", 32'(t >= 400 / DIVN[j] - 1 && t <= 400 / DIVN[j] + 1), 1);
        end
        chk("pin pair", recovered_clock_pins_n_out, 4'(~recovered_clock_pins_p_out));
        pulses(1'b1, t);
        chk("other source", t, 0);
        reg_wr(2'd0, CTL, 16'h0B8C);
        pulses(1'b1, t);
        chk("vco source", 32'(t >= 99 && t <= 101), 1);
        reg_wr(2'd0, CTL, 16'h0B80);
        pulses(1'b0, t);
        chk("held", t, 0);
        reg_wr(2'd0, CTL, 16'h0B18);
        pulses(1'b0, t);
        chk("reserved code", t, 0);
    endtask

    // ==========================================================
    // Main sequence and watchdog
    initial begin
        cyc(5);
        srst_in = 1'b0;
        cyc(10);
        t_reset();
        t_pll();
        t_power();
        t_mode();
        t_ref();
        t_div();
        end_of_test();
    end

    initial begin
        repeat (90000) @(posedge clk_in);
        n_mismatch++;
        end_of_test();
    end
endmodule
